// File: hdl/bmsc_defs.svh
// Constants of the background medium scan controller: page layout,
// reset values, bit positions and time base figures.
// Assumes it is included by bare name from the package and the modules.
`ifndef BMSC_DEFS_SVH
`define BMSC_DEFS_SVH

// ****************************************************************
// Page identity
// ****************************************************************
`define BMSC_PAGE_HEADER 8'hDC
`define BMSC_SUBPAGE 8'h01
`define BMSC_PAGE_LEN 16'h000C

// ****************************************************************
// Byte offsets within the page
// ****************************************************************
`define BMSC_OFS_HEADER 4'h0
`define BMSC_OFS_SUBPAGE 4'h1
`define BMSC_OFS_LEN_HI 4'h2
`define BMSC_OFS_LEN_LO 4'h3
`define BMSC_OFS_SCAN_CTL 4'h4
`define BMSC_OFS_PS_CTL 4'h5
`define BMSC_OFS_INTV_HI 4'h6
`define BMSC_OFS_INTV_LO 4'h7
`define BMSC_OFS_LIMIT_HI 4'h8
`define BMSC_OFS_LIMIT_LO 4'h9
`define BMSC_OFS_IDLE_HI 4'hA
`define BMSC_OFS_IDLE_LO 4'hB
`define BMSC_OFS_SUSP_HI 4'hC
`define BMSC_OFS_SUSP_LO 4'hD

// ****************************************************************
// Bit positions and reset values
// ****************************************************************
`define BMSC_BIT_SCAN_EN 0
`define BMSC_BIT_LOG_UNREC 1
`define BMSC_BIT_SUSP_FULL 2
`define BMSC_BIT_PS_EN 0
`define BMSC_RST_INTERVAL 16'h00A8
`define BMSC_RST_LIMIT 16'h0000
`define BMSC_RST_IDLE 16'h0000
`define BMSC_RST_SUSP 16'h0000

// ****************************************************************
// Time base
// ****************************************************************
`define BMSC_CLK_KHZ 50000
`define BMSC_TICK_MS 50
`define BMSC_HOUR_MS 3600000
`define BMSC_IDLE_ZERO_MS 17'h003E8
`define BMSC_IDLE_FLOOR_MS 17'h00064

`endif

// File: hdl/bmsc_pkg.sv
// Types shared by the background medium scan controller modules.
// Assumes bmsc_defs.svh is on the include path.
`include "bmsc_defs.svh"

package bmsc_pkg;

	// Live configuration taken from the mode page
	typedef struct packed {
		logic suspend_on_full;
		logic log_unrecovered_only;
		logic medium_scan_enable;
		logic prescan_enable;
		logic [15:0] interval_h;
		logic [15:0] limit_h;
		logic [15:0] idle_ms;
		logic [15:0] suspend_lim;
	} bmsc_cfg_t;

	// Medium error report from the scan engine
	typedef struct packed {
		logic valid;
		logic unrecovered;
	} bmsc_err_t;

	// Pre-scan life cycle
	typedef enum logic [2:0] {
		PS_DISARMED,
		PS_ARMED,
		PS_PENDING,
		PS_RUN,
		PS_SPENT
	} bmsc_ps_state_t;

endpackage

// File: hdl/bmsc_tick.sv
// Time base of the scan controller: a 50 ms tick and an hour pulse
// derived from that tick. Assumes a free running clock.
`timescale 1ns/1ps
`default_nettype none
`include "bmsc_defs.svh"

module bmsc_tick #(
	parameter int TICK_CYCLES = `BMSC_TICK_MS * `BMSC_CLK_KHZ,
	parameter int TICKS_PER_HOUR = `BMSC_HOUR_MS / `BMSC_TICK_MS
) (
	input wire logic clk_in,
	input wire logic rst_in,
	output logic tick_out,
	output logic hour_out
);

	logic [31:0] cyc_q;
	logic [31:0] tck_q;
	logic cyc_end;
	logic hr_end;

	// Wrap points of both counters
	assign cyc_end = (cyc_q == 32'(TICK_CYCLES - 1));
	assign hr_end = cyc_end && (tck_q == 32'(TICKS_PER_HOUR - 1));

	// ****************************************************************
	// Counters
	// ****************************************************************
	// Hours come from ticks so both scales share one base
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cyc_q <= 32'h00000000;
			tck_q <= 32'h00000000;
			tick_out <= 1'b0;
			hour_out <= 1'b0;
		end else begin
			cyc_q <= cyc_end ? 32'h00000000 : cyc_q + 32'h00000001;
			if (cyc_end) begin
				tck_q <= hr_end ? 32'h00000000 : tck_q + 32'h00000001;
			end
			tick_out <= cyc_end;
			hour_out <= hr_end;
		end
	end

endmodule
`default_nettype wire

// File: hdl/bmsc_top.sv
// Background medium scan controller: mode page storage, scan and
// pre-scan scheduling, idle qualification and results log filtering.
// Assumes the scan engine keeps its own position while run is low,
// and that idle and power cycle levels arrive from outside the clock.
//
// Notes on behaviour
// RL1: Page reads back code 1Ch with subpage flag, subpage 01h, length 0Ch.
// RL2: With suspend-on-full set, a full results log pauses medium scanning.
// RL3: With unrecovered-only set, only unrecovered medium errors reach the log.
// RL4: Medium scan runs only while its enable bit is one.
// RL5: Clearing scan enable suspends the pass; setting it resumes in place.
// RL6: Clearing pre-scan enable while a pre-scan runs halts it.
// RL7: Pre-scan enable arms a pre-scan that starts after the next power cycle.
// RL8: After completion, pre-scan needs enable toggled and another power cycle.
// RL9: Scan starts are at least the programmed hours apart, default 00A8h.
// RL10: Pre-scan running past the programmed hour limit is halted.
// RL11: A zero pre-scan limit never halts on time.
// RL12: Scanning resumes only after the programmed idle time has passed; the free running tick can let it resume up to one tick early.
// RL13: Zero idle time is treated as one second.
// RL14: Nonzero idle time under 100 ms is raised to 100 ms.
// RL15: Idle time is measured with a 50 ms tick.
// RL16: Maximum suspend time is stored and read back but ignored.
// RL17: Two-byte fields are big endian, high byte at lower offset.
// RL18: Hour counters run from the same tick as the idle timer.
`timescale 1ns/1ps
`default_nettype none
`include "bmsc_defs.svh"

module bmsc_top #(
	parameter int TICK_CYCLES = `BMSC_TICK_MS * `BMSC_CLK_KHZ,
	parameter int TICKS_PER_HOUR = `BMSC_HOUR_MS / `BMSC_TICK_MS
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [3:0] pg_addr_in,
	input wire logic pg_wr_in,
	input wire logic [7:0] pg_wdata_in,
	output logic [7:0] pg_rdata_out,
	input wire logic drive_idle_in,
	input wire logic power_cycle_in,
	input wire logic log_full_in,
	input wire logic scan_done_in,
	input wire logic prescan_done_in,
	input wire bmsc_pkg::bmsc_err_t err_in,
	output logic scan_run_out,
	output logic scan_active_out,
	output logic prescan_run_out,
	output logic prescan_halt_out,
	output logic log_write_out
);

	// ****************************************************************
	// Page storage
	// ****************************************************************
	bmsc_pkg::bmsc_cfg_t cfg_q;

	// Merge one written byte into a big endian 16-bit field
	function automatic logic [15:0] put_byte(input logic [15:0] cur, input logic hi, input logic [7:0] b);
		put_byte = hi ? {b, cur[7:0]} : {cur[15:8], b};
	endfunction

	logic wr_scan_ctl;
	logic wr_ps_ctl;
	logic wr_intv;
	logic wr_limit;
	logic wr_idle;
	logic wr_susp;

	// Write decode; header, subpage, length and tail are read only
	assign wr_scan_ctl = pg_wr_in && (pg_addr_in == `BMSC_OFS_SCAN_CTL);
	assign wr_ps_ctl = pg_wr_in && (pg_addr_in == `BMSC_OFS_PS_CTL);
	assign wr_intv = pg_wr_in && (pg_addr_in[3:1] == 3'(`BMSC_OFS_INTV_HI >> 1));
	assign wr_limit = pg_wr_in && (pg_addr_in[3:1] == 3'(`BMSC_OFS_LIMIT_HI >> 1));
	assign wr_idle = pg_wr_in && (pg_addr_in[3:1] == 3'(`BMSC_OFS_IDLE_HI >> 1));
	assign wr_susp = pg_wr_in && (pg_addr_in[3:1] == 3'(`BMSC_OFS_SUSP_HI >> 1));

	logic hi_byte;
	assign hi_byte = ~pg_addr_in[0];

	// Config registers; writes take effect on the next cycle
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cfg_q.suspend_on_full <= 1'b0;
			cfg_q.log_unrecovered_only <= 1'b0;
			cfg_q.medium_scan_enable <= 1'b0;
			cfg_q.prescan_enable <= 1'b0;
			cfg_q.interval_h <= `BMSC_RST_INTERVAL;
			cfg_q.limit_h <= `BMSC_RST_LIMIT;
			cfg_q.idle_ms <= `BMSC_RST_IDLE;
			cfg_q.suspend_lim <= `BMSC_RST_SUSP;
		end else begin
			if (wr_scan_ctl) begin
				cfg_q.suspend_on_full <= pg_wdata_in[`BMSC_BIT_SUSP_FULL];
				cfg_q.log_unrecovered_only <= pg_wdata_in[`BMSC_BIT_LOG_UNREC];
				cfg_q.medium_scan_enable <= pg_wdata_in[`BMSC_BIT_SCAN_EN];
			end
			if (wr_ps_ctl) begin
				cfg_q.prescan_enable <= pg_wdata_in[`BMSC_BIT_PS_EN];
			end
			// RL17: high byte first
			if (wr_intv) begin
				cfg_q.interval_h <= put_byte(cfg_q.interval_h, hi_byte, pg_wdata_in);
			end
			if (wr_limit) begin
				cfg_q.limit_h <= put_byte(cfg_q.limit_h, hi_byte, pg_wdata_in);
			end
			if (wr_idle) begin
				cfg_q.idle_ms <= put_byte(cfg_q.idle_ms, hi_byte, pg_wdata_in);
			end
			// RL16: stored only
			if (wr_susp) begin
				cfg_q.suspend_lim <= put_byte(cfg_q.suspend_lim, hi_byte, pg_wdata_in);
			end
		end
	end

	// ****************************************************************
	// Page read
	// ****************************************************************
	logic [7:0] rd_mux;

	// RL1: fixed identity bytes
	always_comb begin
		case (pg_addr_in)
			`BMSC_OFS_HEADER: rd_mux = `BMSC_PAGE_HEADER;
			`BMSC_OFS_SUBPAGE: rd_mux = `BMSC_SUBPAGE;
			`BMSC_OFS_LEN_HI: rd_mux = 8'(`BMSC_PAGE_LEN >> 8);
			`BMSC_OFS_LEN_LO: rd_mux = 8'(`BMSC_PAGE_LEN);
			`BMSC_OFS_SCAN_CTL: rd_mux = {5'h00, cfg_q.suspend_on_full, cfg_q.log_unrecovered_only,
				cfg_q.medium_scan_enable};
			`BMSC_OFS_PS_CTL: rd_mux = {7'h00, cfg_q.prescan_enable};
			`BMSC_OFS_INTV_HI: rd_mux = cfg_q.interval_h[15:8];
			`BMSC_OFS_INTV_LO: rd_mux = cfg_q.interval_h[7:0];
			`BMSC_OFS_LIMIT_HI: rd_mux = cfg_q.limit_h[15:8];
			`BMSC_OFS_LIMIT_LO: rd_mux = cfg_q.limit_h[7:0];
			`BMSC_OFS_IDLE_HI: rd_mux = cfg_q.idle_ms[15:8];
			`BMSC_OFS_IDLE_LO: rd_mux = cfg_q.idle_ms[7:0];
			`BMSC_OFS_SUSP_HI: rd_mux = cfg_q.suspend_lim[15:8];
			`BMSC_OFS_SUSP_LO: rd_mux = cfg_q.suspend_lim[7:0];
			default: rd_mux = 8'h00;
		endcase
	end

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic idle_s1_q;
	logic idle_s2_q;
	logic pwr_s1_q;
	logic pwr_s2_q;
	logic pwr_s3_q;
	logic pwr_rise;

	// Second flop is the only reader of the first
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			idle_s1_q <= 1'b0;
			idle_s2_q <= 1'b0;
			pwr_s1_q <= 1'b0;
			pwr_s2_q <= 1'b0;
			pwr_s3_q <= 1'b0;
		end else begin
			idle_s1_q <= drive_idle_in;
			idle_s2_q <= idle_s1_q;
			pwr_s1_q <= power_cycle_in;
			pwr_s2_q <= pwr_s1_q;
			pwr_s3_q <= pwr_s2_q;
		end
	end

	assign pwr_rise = pwr_s2_q & ~pwr_s3_q;

	// ****************************************************************
	// Time base and idle qualification
	// ****************************************************************
	logic tick;
	logic hour;

	// RL15: 50 ms tick
	// RL18: hours counted off the same tick
	bmsc_tick #(
		.TICK_CYCLES(TICK_CYCLES),
		.TICKS_PER_HOUR(TICKS_PER_HOUR)
	) i_bmsc_tick (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.tick_out(tick),
		.hour_out(hour)
	);

	logic [16:0] idle_eff_ms;
	logic [16:0] idle_thr;
	logic [15:0] idle_cnt_q;
	logic idle_ok;

	// RL13: zero means one second
	// RL14: floor of 100 ms
	assign idle_eff_ms = (cfg_q.idle_ms == 16'h0000) ? `BMSC_IDLE_ZERO_MS :
		({1'b0, cfg_q.idle_ms} < `BMSC_IDLE_FLOOR_MS) ? `BMSC_IDLE_FLOOR_MS : {1'b0, cfg_q.idle_ms};
	// Round up to whole ticks; the free running tick can still cut the wait short by up to one tick
	assign idle_thr = 17'((idle_eff_ms + 17'(`BMSC_TICK_MS - 1)) / 17'(`BMSC_TICK_MS));
	// RL12: idle long enough
	assign idle_ok = ({1'b0, idle_cnt_q} >= idle_thr);

	// Idle counter restarts on any host activity, saturates
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			idle_cnt_q <= 16'h0000;
		end else if (!idle_s2_q) begin
			idle_cnt_q <= 16'h0000;
		end else if (tick && idle_cnt_q != 16'hFFFF) begin
			idle_cnt_q <= idle_cnt_q + 16'h0001;
		end
	end

	// ****************************************************************
	// Pre-scan life cycle
	// ****************************************************************
	bmsc_pkg::bmsc_ps_state_t ps_q;
	bmsc_pkg::bmsc_ps_state_t ps_d;
	logic [16:0] ps_hours_q;
	logic ps_over;
	logic ps_halt_d;

	// RL10: limit exceeded
	// Strict compare: the first hour pulse may come right after entry
	// RL11: zero limit never expires
	assign ps_over = (cfg_q.limit_h != 16'h0000) && (ps_hours_q > {1'b0, cfg_q.limit_h});

	always_comb begin
		ps_d = ps_q;
		ps_halt_d = 1'b0;
		case (ps_q)
			bmsc_pkg::PS_DISARMED: begin
				// RL7: arm, wait for power cycle
				if (cfg_q.prescan_enable) begin
					ps_d = bmsc_pkg::PS_ARMED;
				end
			end
			bmsc_pkg::PS_ARMED: begin
				if (!cfg_q.prescan_enable) begin
					ps_d = bmsc_pkg::PS_DISARMED;
				end else if (pwr_rise) begin
					ps_d = bmsc_pkg::PS_PENDING;
				end
			end
			bmsc_pkg::PS_PENDING: begin
				if (!cfg_q.prescan_enable) begin
					ps_d = bmsc_pkg::PS_DISARMED;
				end else if (idle_ok) begin
					ps_d = bmsc_pkg::PS_RUN;
				end
			end
			bmsc_pkg::PS_RUN: begin
				// RL6: disable halts a running pre-scan
				if (!cfg_q.prescan_enable) begin
					ps_d = bmsc_pkg::PS_DISARMED;
					ps_halt_d = 1'b1;
				end else if (prescan_done_in) begin
					ps_d = bmsc_pkg::PS_SPENT;
				end else if (ps_over) begin
					ps_d = bmsc_pkg::PS_SPENT;
					ps_halt_d = 1'b1;
				end
			end
			bmsc_pkg::PS_SPENT: begin
				// RL8: only a disable then enable re-arms
				if (!cfg_q.prescan_enable) begin
					ps_d = bmsc_pkg::PS_DISARMED;
				end
			end
			default: begin
				ps_d = bmsc_pkg::PS_DISARMED;
			end
		endcase
	end

	// Pre-scan state and its elapsed hours, counted suspended or not
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ps_q <= bmsc_pkg::PS_DISARMED;
			ps_hours_q <= 17'h00000;
		end else begin
			ps_q <= ps_d;
			if (ps_q != bmsc_pkg::PS_RUN) begin
				ps_hours_q <= 17'h00000;
			end else if (hour && ps_hours_q != 17'h1FFFF) begin
				ps_hours_q <= ps_hours_q + 17'h00001;
			end
		end
	end

	// ****************************************************************
	// Medium scan scheduling
	// ****************************************************************
	logic [16:0] since_start_q;
	logic scan_act_q;
	logic scan_start;
	logic scan_run_d;
	logic ps_run_d;
	logic log_blocked;

	// RL2: full log pauses only when asked
	assign log_blocked = cfg_q.suspend_on_full & log_full_in;
	// RL9: interval since last start elapsed
	// RL4: enable required
	// Strict compare: the first hour pulse after a start may come at once
	assign scan_start = !scan_act_q && cfg_q.medium_scan_enable && idle_ok &&
		(since_start_q > {1'b0, cfg_q.interval_h}) && (ps_d != bmsc_pkg::PS_RUN);
	// RL5: active pass held while disabled, resumes from engine position
	// Gated by next pre-scan state so both engines never advance together
	assign scan_run_d = (scan_act_q || scan_start) && cfg_q.medium_scan_enable && idle_ok &&
		!log_blocked && (ps_d != bmsc_pkg::PS_RUN) && !scan_done_in;
	// RL12: pre-scan also waits for idle
	assign ps_run_d = (ps_d == bmsc_pkg::PS_RUN) && idle_ok;

	// Pass tracking; counter starts from power-up at zero hours
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			scan_act_q <= 1'b0;
			since_start_q <= 17'h00000;
		end else begin
			if (scan_start) begin
				scan_act_q <= 1'b1;
			end else if (scan_done_in) begin
				scan_act_q <= 1'b0;
			end
			if (scan_start) begin
				since_start_q <= 17'h00000;
			end else if (hour && since_start_q != 17'h1FFFF) begin
				since_start_q <= since_start_q + 17'h00001;
			end
		end
	end

	// ****************************************************************
	// Registered outputs
	// ****************************************************************
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pg_rdata_out <= 8'h00;
			scan_run_out <= 1'b0;
			scan_active_out <= 1'b0;
			prescan_run_out <= 1'b0;
			prescan_halt_out <= 1'b0;
			log_write_out <= 1'b0;
		end else begin
			pg_rdata_out <= rd_mux;
			scan_run_out <= scan_run_d;
			scan_active_out <= (scan_act_q & ~scan_done_in) | scan_start; // Drops with done
			prescan_run_out <= ps_run_d;
			prescan_halt_out <= ps_halt_d;
			// RL3: filter recovered errors
			log_write_out <= err_in.valid & (~cfg_q.log_unrecovered_only | err_in.unrecovered);
		end
	end

endmodule
`default_nettype wire

// File: test/bmsc_top_asserts.sv
// Port checker for the scan controller: output timing against its causes.
// Assumes it is bound to bmsc_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module bmsc_top_asserts #(
	parameter int TICK_CYCLES = 10,
	parameter int TICKS_PER_HOUR = 4
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [3:0] pg_addr_in,
	input wire logic [7:0] pg_rdata_out,
	input wire logic drive_idle_in,
	input wire logic scan_done_in,
	input wire logic prescan_done_in,
	input wire bmsc_pkg::bmsc_err_t err_in,
	input wire logic scan_run_out,
	input wire logic scan_active_out,
	input wire logic prescan_run_out,
	input wire logic prescan_halt_out,
	input wire logic log_write_out
);
	// ********
	// Relations
	// ********
	default clocking dflt_cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	header_read_a: assert property (pg_addr_in == 4'h0 |=> pg_rdata_out == 8'hDC)
		else $error("header byte wrong");
	log_source_a: assert property (log_write_out |-> $past(err_in.valid))
		else $error("log write without error");
	run_active_a: assert property (scan_run_out |-> scan_active_out)
		else $error("scan runs outside a pass");
	done_clear_a: assert property (scan_done_in && scan_active_out |=> !scan_active_out && !scan_run_out)
		else $error("pass not closed by done");
	// Minimum threshold is two ticks, far longer than eight cycles
	idle_seen_a: assert property ($rose(scan_run_out) || $rose(prescan_run_out) |->
		$past(drive_idle_in, 4) && $past(drive_idle_in, 8))
		else $error("run started without idle");
	idle_drop_a: assert property ($fell(drive_idle_in) |-> ##[1:5] (!scan_run_out && !prescan_run_out))
		else $error("run kept after idle ended");
	prescan_owns_a: assert property (prescan_run_out |-> !scan_run_out)
		else $error("scan runs beside pre-scan");
	halt_pulse_a: assert property (prescan_halt_out |-> !prescan_run_out ##1 !prescan_halt_out)
		else $error("halt pulse malformed");
	prescan_end_a: assert property (prescan_done_in && prescan_run_out |=> !prescan_run_out && !prescan_halt_out)
		else $error("pre-scan not ended by done");
endmodule

`default_nettype wire

// File: test/bmsc_engine_model.sv
// Scan engine model: walks a position while allowed to run and reports
// completion of a pass. Assumes the controller's clock and reset.
`timescale 1ns/1ps
`default_nettype none

module bmsc_engine_model #(
	parameter int SCAN_LEN = 60,
	parameter int PS_LEN = 300
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic scan_run_in,
	input wire logic prescan_run_in,
	input wire logic prescan_halt_in,
	output logic scan_done_out,
	output logic prescan_done_out
);
	// ********
	// Positions
	// ********
	int scan_pos_q;
	int ps_pos_q;

	// keeps saved position
	// Position moves only while run is high, so a suspended pass resumes in place
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			scan_pos_q <= 0;
			scan_done_out <= 1'b0;
		end else begin
			scan_done_out <= scan_run_in && !scan_done_out && scan_pos_q == SCAN_LEN - 1;
			if (scan_done_out)
				scan_pos_q <= 0;
			else if (scan_run_in)
				scan_pos_q <= scan_pos_q + 1;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ps_pos_q <= 0;
			prescan_done_out <= 1'b0;
		end else begin
			prescan_done_out <= prescan_run_in && !prescan_done_out && ps_pos_q == PS_LEN - 1;
			if (prescan_done_out || prescan_halt_in)
				ps_pos_q <= 0;
			else if (prescan_run_in)
				ps_pos_q <= ps_pos_q + 1;
		end
	end
endmodule

`default_nettype wire

// File: test/tb_bmsc_top.sv
// Bench for the scan controller: page access, log filter, scan and
// pre-scan scheduling. Assumes the package, checker and engine model.
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
	$display("ERROR t=%0t got %0h exp %0h", $time, got, exp); end end

bind bmsc_top bmsc_top_asserts #(.TICK_CYCLES(TICK_CYCLES), .TICKS_PER_HOUR(TICKS_PER_HOUR)) i_bmsc_top_asserts (
	.clk_in(clk_in), .rst_in(rst_in), .pg_addr_in(pg_addr_in), .pg_rdata_out(pg_rdata_out),
	.drive_idle_in(drive_idle_in), .scan_done_in(scan_done_in), .prescan_done_in(prescan_done_in),
	.err_in(err_in), .scan_run_out(scan_run_out), .scan_active_out(scan_active_out),
	.prescan_run_out(prescan_run_out), .prescan_halt_out(prescan_halt_out), .log_write_out(log_write_out));

module tb_bmsc_top;
	// ********
	// Signals
	// ********
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] pg_addr = 4'h0;
	logic pg_wr = 1'b0;
	logic [7:0] pg_wdata = 8'h00;
	logic [7:0] pg_rdata;
	logic drive_idle = 1'b0;
	logic power_cycle = 1'b0;
	logic log_full = 1'b0;
	logic scan_done;
	logic prescan_done;
	bmsc_pkg::bmsc_err_t err = '0;
	logic scan_run;
	logic scan_active;
	logic prescan_run;
	logic prescan_halt;
	logic log_write;
	logic act_d = 1'b0;
	int n_errors = 0;
	int tests_run = 0;
	int cycles = 0;
	int start_cyc = 0;
	int prev_start = 0;
	int halts = 0;
	int n;
	wire logic [5:0] mon;
	logic [7:0] rst_vals [16] = '{8'hDC, 8'h01, 8'h00, 8'h0C, 8'h00, 8'h00, 8'h00, 8'hA8,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	assign mon = {!prescan_run, !scan_active, scan_active, prescan_halt, prescan_run, scan_run};

	// One hour is 40 cycles here, so long counts stay short
	bmsc_top #(.TICK_CYCLES(10), .TICKS_PER_HOUR(4)) i_bmsc_top (
		.clk_in(clk), .rst_in(rst), .pg_addr_in(pg_addr), .pg_wr_in(pg_wr), .pg_wdata_in(pg_wdata),
		.pg_rdata_out(pg_rdata), .drive_idle_in(drive_idle), .power_cycle_in(power_cycle),
		.log_full_in(log_full), .scan_done_in(scan_done), .prescan_done_in(prescan_done), .err_in(err),
		.scan_run_out(scan_run), .scan_active_out(scan_active), .prescan_run_out(prescan_run),
		.prescan_halt_out(prescan_halt), .log_write_out(log_write));

	bmsc_engine_model #(.SCAN_LEN(60), .PS_LEN(300)) i_bmsc_engine_model (
		.clk_in(clk), .rst_in(rst), .scan_run_in(scan_run), .prescan_run_in(prescan_run),
		.prescan_halt_in(prescan_halt), .scan_done_out(scan_done), .prescan_done_out(prescan_done));

	// Clock, start times of passes, halt count and hang guard
	initial begin
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		act_d <= scan_active;
		if (prescan_halt)
			halts <= halts + 1;
		if (scan_active && !act_d) begin
			prev_start <= start_cyc;
			start_cyc <= cycles;
		end
		if (cycles == 6000) begin
			n_errors++;
			$display("ERROR t=%0t timeout", $time);
			final_report();
		end
	end

	// ********
	// Tasks
	// ********
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge clk);
		pg_addr = a;
		pg_wdata = d;
		pg_wr = 1'b1;
		@(negedge clk);
		pg_wr = 1'b0;
	endtask
	// High byte at the even offset
	task automatic wr16(input logic [3:0] a, input logic [15:0] d);
		wr(a, d[15:8]);
		wr(a + 4'h1, d[7:0]);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(negedge clk);
		pg_addr = a;
		@(negedge clk);
		`CHK(pg_rdata, e)
	endtask
	task automatic err_chk(input logic unrec, input logic e);
		@(negedge clk);
		err = {1'b1, unrec};
		@(negedge clk);
		err = '0;
		`CHK(log_write, e)
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask
	// Bounded wait; n holds the cycles spent
	task automatic wait_sig(input int w, input int lim);
		n = 0;
		while (mon[w] !== 1'b1 && n < lim) begin
			@(negedge clk);
			n++;
		end
	endtask
	// Low for a few cycles first so the rise is seen as a fresh edge
	task automatic pwr_up();
		@(negedge clk);
		power_cycle = 1'b0;
		cyc(4);
		power_cycle = 1'b1;
	endtask
	task automatic final_report();
		$display("Checks %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ********
	// Sequence
	// ********
	initial begin
		repeat (4) @(negedge clk);
		rst = 1'b0;
		for (int i = 0; i < 16; i++)
			rd(i[3:0], rst_vals[i]);
		wr(4'h0, 8'h00);
		wr(4'h3, 8'hFF);
		wr(4'h4, 8'hFF);
		wr(4'h5, 8'hFF);
		wr(4'hE, 8'hFF);
		wr16(4'hC, 16'h1234);
		rd(4'h0, 8'hDC);
		rd(4'h3, 8'h0C);
		rd(4'h4, 8'h07);
		rd(4'h5, 8'h01);
		rd(4'hE, 8'h00);
		rd(4'hC, 8'h12);
		rd(4'hD, 8'h34);
		wr(4'h5, 8'h00);
		wr(4'h4, 8'h00);
		$display("Test page done");
		err_chk(1'b0, 1'b1);
		err_chk(1'b1, 1'b1);
		wr(4'h4, 8'h02);
		err_chk(1'b0, 1'b0);
		err_chk(1'b1, 1'b1);
		$display("Test log filter done");
		wr16(4'h6, 16'h0004);
		wr(4'h4, 8'h01);
		drive_idle = 1'b1;
		wait_sig(0, 300);
		`CHK(n >= 180 && n <= 215, 1'b1)
		drive_idle = 1'b0;
		cyc(6);
		`CHK(scan_run, 1'b0)
		`CHK(scan_active, 1'b1)
		wr16(4'hA, 16'h0032);
		drive_idle = 1'b1;
		wait_sig(0, 60);
		`CHK(n >= 11 && n <= 30, 1'b1)
		cyc(5);
		wr(4'h4, 8'h00);
		cyc(3);
		`CHK(scan_run, 1'b0)
		`CHK(scan_active, 1'b1)
		wr(4'h4, 8'h01);
		cyc(3);
		`CHK(scan_run, 1'b1)
		log_full = 1'b1;
		cyc(3);
		`CHK(scan_run, 1'b1)
		wr(4'h4, 8'h05);
		cyc(3);
		`CHK(scan_run, 1'b0)
		log_full = 1'b0;
		cyc(3);
		`CHK(scan_run, 1'b1)
		wait_sig(4, 100);
		`CHK(scan_active, 1'b0)
		wait_sig(3, 300);
		// Start times are taken one edge after the rise
		cyc(1);
		`CHK(start_cyc - prev_start >= 160 && start_cyc - prev_start <= 215, 1'b1)
		$display("Test scan schedule done");
		wr(4'h5, 8'h01);
		cyc(40);
		`CHK(prescan_run, 1'b0)
		pwr_up();
		wait_sig(1, 15);
		`CHK(prescan_run, 1'b1)
		cyc(2);
		`CHK(scan_run, 1'b0)
		cyc(200);
		`CHK(halts, 0)
		`CHK(prescan_run, 1'b1)
		wr(4'h5, 8'h00);
		wait_sig(2, 5);
		`CHK(prescan_halt, 1'b1)
		cyc(1);
		`CHK(prescan_run, 1'b0)
		wr16(4'h8, 16'h0001);
		wr(4'h5, 8'h01);
		pwr_up();
		wait_sig(1, 15);
		`CHK(prescan_run, 1'b1)
		wait_sig(2, 120);
		`CHK(n >= 36 && n <= 95, 1'b1)
		pwr_up();
		cyc(20);
		`CHK(prescan_run, 1'b0)
		wr16(4'h8, 16'h0000);
		wr(4'h5, 8'h00);
		wr(4'h5, 8'h01);
		pwr_up();
		wait_sig(1, 15);
		`CHK(prescan_run, 1'b1)
		wait_sig(5, 400);
		`CHK(halts, 2)
		pwr_up();
		cyc(20);
		`CHK(prescan_run, 1'b0)
		$display("Test pre-scan done");
		final_report();
	end
endmodule

`default_nettype wire
